// ==== dv/fp_coprocessor_exception_control_test.sv ====
// self-checking bench for exception, interrupt and context control
module fp_coprocessor_exception_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h3C;
  typedef struct packed {logic [7:0] mask; logic [7:0] flags; logic irq;} row_s;
  localparam row_s ROWS [5] = '{'{8'hFF, 8'h01, 1'b0}, '{8'hFE, 8'h01, 1'b1},
    '{8'h7F, 8'h80, 1'b1}, '{8'h00, 8'h24, 1'b1}, '{8'hF0, 8'h0F, 1'b1}};
  localparam fpx_pkg::op_e NEWOPS [3] = '{fpx_pkg::OP_SQRT, fpx_pkg::OP_RSUB, fpx_pkg::OP_DMAC};
  logic mclk_in = 1'b0, nrst_in = 1'b0, compat_mode_in = 1'b0, irq_out;
  fpx_pkg::host_req_s req_in;
  fpx_pkg::exc_event_s exc_in = '0;
  fpx_pkg::host_rsp_s rsp_out;
  fpx_pkg::exec_cmd_s exec_out;
  fpx_pkg::ctl_cmd_s ctl_out;
  logic [1:0] round_mode_out;
  logic [7:0] exc_mask_out, exc_accum_out, rev;
  logic [31:0] d;
  int failures = 0, compares = 0, cycles = 0, ctl_cnt = 0, base;
  always #2 mclk_in = ~mclk_in;
  fp_coprocessor_exception_control #(.REVISION(REV)) u_fp_coprocessor_exception_control (
    .mclk_in, .nrst_in, .req_in, .exc_in, .compat_mode_in, .rsp_out, .exec_out, .ctl_out,
    .irq_out, .round_mode_out, .exc_mask_out, .exc_accum_out);
  host_model u_host_model (.mclk_in, .rsp_in(rsp_out), .req_out(req_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic pulse(input logic [7:0] f);
    @(posedge mclk_in) exc_in <= {1'b1, f};
    @(posedge mclk_in) exc_in <= '0;
    @(posedge mclk_in) #1;
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (ctl_out.valid) ctl_cnt <= ctl_cnt + 1;
    // generous ceiling: the whole sequence needs well under a thousand cycles
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    repeat (12) @(posedge mclk_in);
    nrst_in <= 1'b1;
    #1 check(irq_out, 0);
    check({round_mode_out, exc_mask_out, exc_accum_out}, 18'h3_FF00);
    foreach (ROWS[i]) begin
      u_host_model.ld({8'h03, ROWS[i].mask, 16'h0000});
      pulse(ROWS[i].flags);
      check(irq_out, ROWS[i].irq);
      check(exc_accum_out, ROWS[i].flags);
    end
    u_host_model.ld(32'h0300_0000);
    pulse(8'h04);
    u_host_model.issue(fpx_pkg::OP_LOAD_REG, 5'h03, 32'h0000_1234);
    u_host_model.fetch(fpx_pkg::OP_STORE_CTX, 5'h00, d);
    check(d, 32'h0300_0004);
    check(irq_out, 1);
    u_host_model.ld(32'h0304_0004);
    #1 check(irq_out, 0);
    check(exc_accum_out, 8'h04);
    u_host_model.ld(32'h0300_0004);
    #1 check(irq_out, 1);
    u_host_model.fetch(fpx_pkg::OP_STORE_CTX, 5'h00, d);
    u_host_model.ld({d[31:8], 8'h00});
    #1 check(irq_out, 0);
    for (int c = 0; c < 2; c++) begin
      @(posedge mclk_in) compat_mode_in <= c[0];
      u_host_model.ld(32'h03FF_0000);
      foreach (NEWOPS[k]) begin
        u_host_model.issue(NEWOPS[k], 5'h01, 32'h0000_0000);
        #1 check(exec_out.valid, !c[0]);
      end
      u_host_model.issue(fpx_pkg::OP_ARITH, 5'h07, 32'h0000_0000);
      #1 check(exec_out.valid, 1'h1);
      check(exec_out.idx, 5'h07);
      check(exec_out.op, fpx_pkg::OP_ARITH);
      check(exc_accum_out[0], c[0]);
    end
    for (int i = 0; i < 32; i++)
      u_host_model.issue(fpx_pkg::OP_LOAD_REG, i[4:0], {i[7:0], ~i[7:0], i[7:0], 8'hA5});
    for (int i = 0; i < 32; i++) begin
      u_host_model.fetch(fpx_pkg::OP_STORE_REG, i[4:0], d);
      check(d, {i[7:0], ~i[7:0], i[7:0], 8'hA5});
    end
    base = ctl_cnt;
    u_host_model.init_seq(rev);
    check(rev, REV);
    @(posedge mclk_in) #1;
    check(ctl_cnt - base, 6);
    check({round_mode_out, exc_mask_out, exc_accum_out}, 18'h3_FF00);
    // reset in mid-run with a pending interrupt and a loaded register file
    u_host_model.ld(32'h0300_0000);
    pulse(8'h02);
    check(irq_out, 1'h1);
    @(posedge mclk_in) nrst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    #1 check(irq_out, 1'h0);
    check({round_mode_out, exc_mask_out, exc_accum_out}, 18'h3_FF00);
    u_host_model.fetch(fpx_pkg::OP_STORE_REG, 5'h03, d);
    check(d, 32'h0000_0000);
    report_and_stop();
  end
endmodule
bind fp_coprocessor_exception_control fpx_sva #(.REVISION(REVISION)) u_fpx_sva (
  .mclk_in, .nrst_in, .req_in, .exc_in, .compat_mode_in, .rsp_out, .exec_out, .ctl_out,
  .irq_out, .round_mode_out, .exc_mask_out, .exc_accum_out);

// ==== dv/fpx_sva.sv ====
// port checker for exception, interrupt and context control
module fpx_sva #(
  parameter logic [fpx_pkg::REV_W-1:0] REVISION = fpx_pkg::REVISION_DEFAULT
) (
  input wire logic                mclk_in,
  input wire logic                nrst_in,
  input wire fpx_pkg::host_req_s  req_in,
  input wire fpx_pkg::exc_event_s exc_in,
  input wire logic                compat_mode_in,
  input wire fpx_pkg::host_rsp_s  rsp_out,
  input wire fpx_pkg::exec_cmd_s  exec_out,
  input wire fpx_pkg::ctl_cmd_s   ctl_out,
  input wire logic                irq_out,
  input wire logic [1:0]          round_mode_out,
  input wire logic [7:0]          exc_mask_out,
  input wire logic [7:0]          exc_accum_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire ld = req_in.valid && req_in.op == fpx_pkg::OP_LOAD_CTX;
  wire plain = ld && req_in.data[31:26] == 6'h00;
  wire nop = req_in.valid && req_in.op inside {fpx_pkg::OP_SQRT, fpx_pkg::OP_RSUB, fpx_pkg::OP_DMAC};
  sequence arm_s; ld && req_in.data == fpx_pkg::REV_SELECT_WORD; endsequence
  sequence ask_s; req_in.valid && req_in.op == fpx_pkg::OP_STORE_CTX; endsequence
  irq_raise_a:
    assert property (exc_in.valid && |(exc_in.flags & ~exc_mask_out) && !ld |=> irq_out)
      else $error("irq missing after unmasked event");
  irq_match_a:
    assert property (irq_out == |(exc_accum_out & ~exc_mask_out)) else $error("irq mismatch");
  irq_hold_a:
    assert property (irq_out && !ld |=> irq_out) else $error("irq dropped without clear");
  mask_clear_a:
    assert property (irq_out && plain && !exc_in.valid && req_in.data[7:0] == exc_accum_out
      && (req_in.data[7:0] & ~req_in.data[23:16]) == 8'h00 |=> !irq_out && $stable(exc_accum_out))
      else $error("masking did not clear irq");
  accum_clear_a:
    assert property (irq_out && plain && !exc_in.valid && req_in.data[7:0] == 8'h00
      |=> !irq_out && exc_accum_out == 8'h00) else $error("flag clear kept irq");
  plain_load_a:
    assert property (plain && !exc_in.valid |=> {round_mode_out, exc_mask_out, exc_accum_out}
      == {$past(req_in.data[25:16]), $past(req_in.data[7:0])}) else $error("ctx load wrong");
  rev_read_a:
    assert property (arm_s ##1 !req_in.valid ##1 ask_s |=> rsp_out.valid
      && rsp_out.data == {16'h0000, REVISION, 8'h00}) else $error("revision readback wrong");
  cmd_fwd_a:
    assert property (ld && !plain |=> ctl_out.valid && ctl_out.word == $past(req_in.data)
      && ctl_out.code == $past(req_in.data[31:26])) else $error("command word not forwarded");
  op_dispatch_a:
    assert property (nop && !compat_mode_in |=> exec_out.valid
      && exec_out.op == $past(req_in.op) && exec_out.idx == $past(req_in.idx))
      else $error("new op not dispatched");
  compat_flag_a:
    assert property (nop && compat_mode_in |=> !exec_out.valid && exc_accum_out[0])
      else $error("compat op not flagged");
endmodule

// ==== dv/host_model.sv ====
// host processor model issuing coprocessor requests
module host_model #(
  // arbitrary value standing for the oldest revision level
  parameter logic [7:0] OLDEST_REV = 8'hC3
) (
  input  wire logic               mclk_in,
  input  wire fpx_pkg::host_rsp_s rsp_in,
  output fpx_pkg::host_req_s      req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  task automatic issue(input fpx_pkg::op_e op, input logic [4:0] i, input logic [31:0] w);
    @(posedge mclk_in);
    req_out <= {1'b1, op, i, w};
    @(posedge mclk_in);
    // idle bus shows the inverse, never a stale word
    req_out <= {1'b0, fpx_pkg::OP_NONE, ~i, ~w};
  endtask
  task automatic ld(input logic [31:0] w);
    issue(fpx_pkg::OP_LOAD_CTX, 5'h00, w);
  endtask
  task automatic fetch(input fpx_pkg::op_e op, input logic [4:0] i, output logic [31:0] w);
    issue(op, i, 32'h0000_0000);
    #1 w = rsp_in.valid ? rsp_in.data : 'x;
  endtask
  task automatic init_seq(output logic [7:0] rev);
    logic [31:0] w;
    ld(fpx_pkg::INIT_CTX_WORD);
    ld(fpx_pkg::REV_SELECT_WORD);
    fetch(fpx_pkg::OP_STORE_CTX, 5'h00, w);
    rev = w[15:8];
    if (rev == OLDEST_REV) begin
      ld(32'h1600_0000);
    end else begin
      ld(32'h5600_0000);
      ld(32'h9800_0000);
    end
    ld(32'h6400_0000);
    ld(32'hA000_0000);
    ld(32'h3000_0000);
  endtask
endmodule

// ==== inc/fpx_pkg.sv ====
// shared constants and types for the coprocessor exception and context control
package fpx_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int unsigned CTX_W     = 32;
  localparam int unsigned NUM_REGS  = 32;
  localparam int unsigned REG_IDX_W = 5;

  // ------------------------------------------------------------------
  // context control word fields
  // ------------------------------------------------------------------
  localparam int unsigned ACC_LSB  = 0;
  localparam int unsigned ACC_W    = 8;
  localparam int unsigned REV_LSB  = 8;
  localparam int unsigned REV_W    = 8;
  localparam int unsigned MASK_LSB = 16;
  localparam int unsigned MASK_W   = 8;
  localparam int unsigned RND_LSB  = 24;
  localparam int unsigned RND_W    = 2;
  localparam int unsigned CMD_LSB  = 26;
  localparam int unsigned CMD_W    = 6;

  // accumulated flag raised for an unsupported opcode in compatible mode
  localparam int unsigned INVALID_BIT = 0;

  // ------------------------------------------------------------------
  // values
  // ------------------------------------------------------------------
  localparam logic [CTX_W-1:0] CTX_RESET       = 32'h03FF_0000;
  localparam logic [CTX_W-1:0] INIT_CTX_WORD   = 32'h03FF_0000;
  localparam logic [CTX_W-1:0] REV_SELECT_WORD = 32'hB800_0000;
  localparam logic [RND_W-1:0] RND_NEAREST     = 2'h3;
  // arbitrary neutral revision level
  localparam logic [REV_W-1:0] REVISION_DEFAULT = 8'h5A;

  // ------------------------------------------------------------------
  // host operations
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_LOAD_REG,
    OP_STORE_REG,
    OP_LOAD_CTX,
    OP_STORE_CTX,
    OP_ARITH,
    OP_SQRT,
    OP_RSUB,
    OP_DMAC
  } op_e;

  typedef struct packed {
    logic                 valid;
    op_e                  op;
    logic [REG_IDX_W-1:0] idx;
    logic [CTX_W-1:0]     data;
  } host_req_s;

  typedef struct packed {
    logic             valid;
    logic [CTX_W-1:0] data;
  } host_rsp_s;

  typedef struct packed {
    logic             valid;
    logic [ACC_W-1:0] flags;
  } exc_event_s;

  typedef struct packed {
    logic                 valid;
    op_e                  op;
    logic [REG_IDX_W-1:0] idx;
  } exec_cmd_s;

  typedef struct packed {
    logic             valid;
    logic [CMD_W-1:0] code;
    logic [CTX_W-1:0] word;
  } ctl_cmd_s;

endpackage

// ==== verilog/ctx_regfile.sv ====
// thirty-two entry architectural register file with asynchronous read
module ctx_regfile #(
  parameter int unsigned DEPTH = fpx_pkg::NUM_REGS,
  parameter int unsigned WIDTH = fpx_pkg::CTX_W,
  parameter int unsigned IDX_W = fpx_pkg::REG_IDX_W
) (
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  input  wire logic             wr_en_in,
  input  wire logic [IDX_W-1:0] wr_idx_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [IDX_W-1:0] rd_idx_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] entry_q [DEPTH];
  logic [WIDTH-1:0] entry_d [DEPTH];

  // ------------------------------------------------------------------
  // one entry per generate step
  // ------------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      entry_d[i] = entry_q[i];
      if (wr_en_in && (wr_idx_in == IDX_W'(i))) begin
        entry_d[i] = wr_data_in;
      end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        entry_q[i] <= '0;
      end else begin
        entry_q[i] <= entry_d[i];
      end
    end
  end

  // read sees the stored value, not a same-cycle write
  assign rd_data_out = entry_q[rd_idx_in];

endmodule

// ==== verilog/fp_coprocessor_exception_control.sv ====
// exception, interrupt and context control for the floating-point coprocessor
module fp_coprocessor_exception_control #(
  parameter logic [fpx_pkg::REV_W-1:0] REVISION = fpx_pkg::REVISION_DEFAULT
) (
  input  wire logic                              mclk_in,
  input  wire logic                              nrst_in,
  input  wire fpx_pkg::host_req_s                req_in,
  input  wire fpx_pkg::exc_event_s               exc_in,
  input  wire logic                              compat_mode_in,
  output fpx_pkg::host_rsp_s                     rsp_out,
  output fpx_pkg::exec_cmd_s                     exec_out,
  output fpx_pkg::ctl_cmd_s                      ctl_out,
  output logic                                   irq_out,
  output logic [fpx_pkg::RND_W-1:0]              round_mode_out,
  output logic [fpx_pkg::MASK_W-1:0]             exc_mask_out,
  output logic [fpx_pkg::ACC_W-1:0]              exc_accum_out
);

  // ------------------------------------------------------------------
  // types and state
  // ------------------------------------------------------------------
  typedef enum logic {
    RB_IDLE,
    RB_ARMED
  } readback_e;

  readback_e                       rb_q;
  readback_e                       rb_d;
  logic [fpx_pkg::CTX_W-1:0]       ctx_q;
  logic [fpx_pkg::CTX_W-1:0]       ctx_d;
  logic                            irq_q;
  logic                            irq_d;
  fpx_pkg::host_rsp_s              rsp_q;
  fpx_pkg::host_rsp_s              rsp_d;
  fpx_pkg::exec_cmd_s              exec_q;
  fpx_pkg::exec_cmd_s              exec_d;
  fpx_pkg::ctl_cmd_s               ctl_q;
  fpx_pkg::ctl_cmd_s               ctl_d;

  logic                            rf_we;
  logic [fpx_pkg::CTX_W-1:0]       rf_rd_data;
  logic [fpx_pkg::ACC_W-1:0]       new_flags;
  logic [fpx_pkg::ACC_W-1:0]       acc_next;
  logic [fpx_pkg::MASK_W-1:0]      mask_next;
  logic [fpx_pkg::CMD_W-1:0]       cmd_field;
  logic [fpx_pkg::CTX_W-1:0]       rev_word;

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  ctx_regfile #(
    .DEPTH (fpx_pkg::NUM_REGS),
    .WIDTH (fpx_pkg::CTX_W),
    .IDX_W (fpx_pkg::REG_IDX_W)
  ) u_regfile (
    .mclk_in     (mclk_in),
    .nrst_in     (nrst_in),
    .wr_en_in    (rf_we),
    .wr_idx_in   (req_in.idx),
    .wr_data_in  (req_in.data),
    .rd_idx_in   (req_in.idx),
    .rd_data_out (rf_rd_data)
  );

  // a nonzero top field marks a control command; such words never reach
  // the stored context, which keeps a save and restore exact
  assign cmd_field = req_in.data[fpx_pkg::CMD_LSB +: fpx_pkg::CMD_W];
  assign rev_word  = fpx_pkg::CTX_W'(REVISION) << fpx_pkg::REV_LSB;

  // ------------------------------------------------------------------
  // host operations and context word
  // ------------------------------------------------------------------
  always_comb begin
    ctx_d     = ctx_q;
    rsp_d     = '0;
    exec_d    = '0;
    ctl_d     = '0;
    rf_we     = 1'b0;
    new_flags = '0;
    acc_next  = '0;
    mask_next = '0;
    irq_d     = 1'b0;

    if (exc_in.valid) begin
      new_flags = exc_in.flags;
    end

    if (req_in.valid) begin
      case (req_in.op)
        fpx_pkg::OP_LOAD_CTX: begin
          if (cmd_field != '0) begin
            // control command word: leaves mode, masks and flags alone
            ctl_d.valid = 1'b1;
            ctl_d.code  = cmd_field;
            ctl_d.word  = req_in.data;
          end else begin
            // plain load also restores a saved word exactly
            ctx_d = req_in.data;
          end
        end
        fpx_pkg::OP_STORE_CTX: begin
          rsp_d.valid = 1'b1;
          if (rb_q == RB_ARMED) begin
            rsp_d.data = rev_word;
          end else begin
            rsp_d.data = ctx_q;
          end
        end
        fpx_pkg::OP_LOAD_REG: begin
          rf_we = 1'b1;
        end
        fpx_pkg::OP_STORE_REG: begin
          rsp_d.valid = 1'b1;
          rsp_d.data  = rf_rd_data;
        end
        // plain arithmetic is dispatched in either mode
        fpx_pkg::OP_ARITH: begin
          exec_d.valid = 1'b1;
          exec_d.op    = req_in.op;
          exec_d.idx   = req_in.idx;
        end
        fpx_pkg::OP_SQRT,
        fpx_pkg::OP_RSUB,
        fpx_pkg::OP_DMAC: begin
          if (compat_mode_in) begin
            new_flags[fpx_pkg::INVALID_BIT] = 1'b1;
          end else begin
            exec_d.valid = 1'b1;
            exec_d.op    = req_in.op;
            exec_d.idx   = req_in.idx;
          end
        end
        default: begin
        end
      endcase
    end

    // a flag arriving with a clearing load survives it
    acc_next  = ctx_d[fpx_pkg::ACC_LSB +: fpx_pkg::ACC_W] | new_flags;
    mask_next = ctx_d[fpx_pkg::MASK_LSB +: fpx_pkg::MASK_W];
    ctx_d[fpx_pkg::ACC_LSB +: fpx_pkg::ACC_W] = acc_next;

    // level function of flags and masks only, so nothing else clears it
    irq_d = |(acc_next & ~mask_next);
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctx_q  <= fpx_pkg::CTX_RESET;
      irq_q  <= 1'b0;
      rsp_q  <= '0;
      exec_q <= '0;
      ctl_q  <= '0;
    end else begin
      ctx_q  <= ctx_d;
      irq_q  <= irq_d;
      rsp_q  <= rsp_d;
      exec_q <= exec_d;
      ctl_q  <= ctl_d;
    end
  end

  // ------------------------------------------------------------------
  // revision readback
  // ------------------------------------------------------------------
  // any other context load disarms, so a stale arm cannot slip the
  // revision into a later context save
  always_comb begin
    rb_d = rb_q;
    if (req_in.valid) begin
      case (req_in.op)
        fpx_pkg::OP_LOAD_CTX: begin
          if (req_in.data == fpx_pkg::REV_SELECT_WORD) begin
            rb_d = RB_ARMED;
          end else begin
            rb_d = RB_IDLE;
          end
        end
        fpx_pkg::OP_STORE_CTX: begin
          // one save only reads the revision; the next sees the word again
          rb_d = RB_IDLE;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rb_q <= RB_IDLE;
    end else begin
      rb_q <= rb_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // mode, mask and flag ports are the stored word itself, so a context
  // save agrees with what the ports show unless a revision select has armed the readback
  assign rsp_out        = rsp_q;
  assign exec_out       = exec_q;
  assign ctl_out        = ctl_q;
  assign irq_out        = irq_q;
  assign round_mode_out = ctx_q[fpx_pkg::RND_LSB +: fpx_pkg::RND_W];
  assign exc_mask_out   = ctx_q[fpx_pkg::MASK_LSB +: fpx_pkg::MASK_W];
  assign exc_accum_out  = ctx_q[fpx_pkg::ACC_LSB +: fpx_pkg::ACC_W];

endmodule
